// ### verilog/sfr_pkg.sv
// Shared constants and types for the serial flash read engine
package sfr_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ      = 8'h03;
	localparam logic [7:0] CMD_FAST      = 8'h0B;
	localparam logic [7:0] CMD_DUAL_OUT  = 8'h3B;
	localparam logic [7:0] CMD_QUAD_OUT  = 8'h6B;
	localparam logic [7:0] CMD_DUAL_IO   = 8'hBB;
	localparam logic [7:0] CMD_QUAD_IO   = 8'hEB;
	localparam logic [7:0] CMD_QUAD_WORD = 8'hE7;
	localparam logic [7:0] CMD_SET_WRAP  = 8'h77;

	// ----------------------------------------------------------------
	// Serial phase lengths and positions, in serial clocks, and the continuous mode match code
	// ----------------------------------------------------------------
	localparam logic [4:0] CMD_CLOCKS        = 5'h08;
	localparam logic [4:0] ADDR_CLOCKS_X1    = 5'h18;
	localparam logic [4:0] ADDR_CLOCKS_X2    = 5'h0C;
	localparam logic [4:0] ADDR_CLOCKS_X4    = 5'h06;
	localparam logic [4:0] MODE_CLOCKS_X2    = 5'h04;
	localparam logic [4:0] MODE_CLOCKS_X4    = 5'h02;
	localparam logic [4:0] DUMMY_CLOCKS_BYTE = 5'h08;
	localparam logic [4:0] DUMMY_CLOCKS_QIO  = 5'h04;
	localparam logic [4:0] DUMMY_CLOCKS_WORD = 5'h02;
	localparam logic [4:0] WRAP_CLOCKS       = 5'h08;
	localparam logic [4:0] WRAP_BITS_CLOCK   = 5'h06;
	localparam logic [1:0] CONT_MODE_MATCH   = 2'h2;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam int         CTRL_QE_POS   = 0;
	localparam int         CTRL_BUSY_POS = 1;
	localparam logic [1:0] CTRL_RESET    = 2'h0;
	localparam logic       WRAP_DIS_RESET = 1'b1;
	localparam logic [1:0] WRAP_LEN_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_ADDR   = 3'h3,
		ST_MODE   = 3'h2,
		ST_DUMMY  = 3'h6,
		ST_DATA   = 3'h7,
		ST_IGNORE = 3'h5,
		ST_WRAP   = 3'h4
	} sfr_state_t;

	typedef enum logic [2:0] {
		K_READ  = 3'h0,
		K_FAST  = 3'h1,
		K_DOUT  = 3'h2,
		K_QOUT  = 3'h3,
		K_DIO   = 3'h4,
		K_QIO   = 3'h5,
		K_QWORD = 3'h6,
		K_WRAP  = 3'h7
	} sfr_kind_t;

endpackage : sfr_pkg

// ### verilog/sfr_sync.sv
// Two-stage synchroniser with edge detection on the settled stage
`timescale 1ns/10ps
module sfr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	input  wire logic [W-1:0] reset_val_i,
	output logic      [W-1:0] sync_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	logic [W-1:0] meta;
	logic [W-1:0] settled;
	logic [W-1:0] last;

	// ----------------------------------------------------------------
	// Capture stages
	// ----------------------------------------------------------------
	// The first stage feeds only the second; edges look at later stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta    <= reset_val_i;
			settled <= reset_val_i;
			last    <= reset_val_i;
		end else begin
			meta    <= async_i;
			settled <= meta;
			last    <= settled;
		end
	end

	// Stages restart at the idle pin levels, so release shows no false select or edge
	assign sync_o = settled;
	assign rise_o = settled & ~last;
	assign fall_o = ~settled & last;

endmodule : sfr_sync

// ### verilog/sfr_engine.sv
// Read-command engine of a serial flash with a Wishbone control port
`timescale 1ns/10ps
// Summary of operation
// R1 - Basic read: command then 24-bit address on IO0, sampled on rising clock.
// R2 - Basic read data leaves on IO1, changing on falling clock edges.
// R3 - Any start byte; address increments after each byte while select low.
// R4 - Reads are ignored while a program or erase cycle is busy.
// R5 - Fast read: command, address, one dummy byte serially, then IO1 data.
// R6 - Dual output read: serial header and dummy byte, data on IO1 and IO0.
// R7 - Quad output read: serial header and dummy byte, data on four lanes.
// R8 - Dual I/O read: address and mode byte two bits per clock, data likewise.
// R9 - Dual I/O mode bits 10 skip the next command code; otherwise required.
// R10 - Quad I/O read: address and mode by four, four dummy clocks, quad data.
// R11 - Quad I/O read runs only with the quad enable bit set; the engine does not check it for continuous mode reads.
// R12 - Quad I/O mode bits 10 skip the next command code; otherwise required.
// R13 - Word read: like quad I/O but only two dummy clocks, even address.
// R14 - Word read runs only with the quad enable bit set; the engine does not check it for continuous mode reads.
// R15 - Word read mode bits 10 skip the next command code; otherwise required.
// R16 - Host clears continuous mode by sending mode bits other than 10.
// R17 - With wrap on, quad I/O reads wrap within the aligned section.
// R18 - Wrap setting: one disable bit and a two-bit section length field.
// R19 - Set wrap: command, 24 dummy bits, 8 wrap bits on quad lanes.
// R20 - Length codes give 8, 16, 32, 64 bytes; disable bit one is default.
// R21 - Quad address nibbles carry four address bits, highest on IO3.
// R22 - Dual data: IO1 odd bits, IO0 even bits, highest pair first.
// R23 - Select high ends any read and releases the data lanes.
// R24 - After reset continuous mode is off and wrap is disabled.
module sfr_engine #(
	parameter int ADDR_W = 24
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Serial flash pins
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic [3:0]        io_i,
	output logic      [3:0]        io_o,
	output logic      [3:0]        io_oe_o,
	// Memory array read port, data valid one clock after the address
	output logic      [ADDR_W-1:0] mem_addr_o,
	input  wire logic [7:0]        mem_data_i
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pin_sync;
	logic [5:0] pin_rise;
	logic [5:0] pin_fall;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_n;
	logic [3:0] io_in;

	sfr_sync #(.W(6)) u_sync (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.async_i    ({cs_n_i, sclk_i, io_i}),
		.reset_val_i(6'h20),
		.sync_o     (pin_sync),
		.rise_o     (pin_rise),
		.fall_o     (pin_fall)
	);

	assign cs_n      = pin_sync[5];
	assign sclk_rise = pin_rise[4];
	assign sclk_fall = pin_fall[4];
	assign io_in     = pin_sync[3:0];

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Lanes used for the address and mode byte
	function automatic logic [2:0] addr_lanes(input sfr_pkg::sfr_kind_t k);
		unique case (k)
			sfr_pkg::K_DIO:                 addr_lanes = 3'h2;
			sfr_pkg::K_QIO, sfr_pkg::K_QWORD: addr_lanes = 3'h4;
			default:                        addr_lanes = 3'h1;
		endcase
	endfunction : addr_lanes

	// Lanes used for data out
	function automatic logic [2:0] data_lanes(input sfr_pkg::sfr_kind_t k);
		unique case (k)
			sfr_pkg::K_DOUT, sfr_pkg::K_DIO: data_lanes = 3'h2;
			sfr_pkg::K_QOUT, sfr_pkg::K_QIO, sfr_pkg::K_QWORD: data_lanes = 3'h4;
			default:                        data_lanes = 3'h1;
		endcase
	endfunction : data_lanes

	function automatic logic [4:0] addr_clocks(input sfr_pkg::sfr_kind_t k);
		unique case (addr_lanes(k))
			3'h2:    addr_clocks = sfr_pkg::ADDR_CLOCKS_X2;
			3'h4:    addr_clocks = sfr_pkg::ADDR_CLOCKS_X4;
			default: addr_clocks = sfr_pkg::ADDR_CLOCKS_X1;
		endcase
	endfunction : addr_clocks

	function automatic logic [4:0] dummy_clocks(input sfr_pkg::sfr_kind_t k);
		unique case (k)
			sfr_pkg::K_FAST, sfr_pkg::K_DOUT, sfr_pkg::K_QOUT: dummy_clocks = sfr_pkg::DUMMY_CLOCKS_BYTE;
			sfr_pkg::K_QIO:   dummy_clocks = sfr_pkg::DUMMY_CLOCKS_QIO;
			sfr_pkg::K_QWORD: dummy_clocks = sfr_pkg::DUMMY_CLOCKS_WORD;
			default:          dummy_clocks = 5'h00;
		endcase
	endfunction : dummy_clocks

	function automatic logic has_mode(input sfr_pkg::sfr_kind_t k);
		has_mode = (k == sfr_pkg::K_DIO) || (k == sfr_pkg::K_QIO) || (k == sfr_pkg::K_QWORD);
	endfunction : has_mode

	// Shift a group of lane bits in, highest lane carrying the highest bit
	function automatic logic [ADDR_W-1:0] shift_in(input logic [ADDR_W-1:0] v, input logic [2:0] w,
	                                              input logic [3:0] io);
		unique case (w)
			3'h2:    shift_in = {v[ADDR_W-3:0], io[1:0]};
			3'h4:    shift_in = {v[ADDR_W-5:0], io[3:0]};
			default: shift_in = {v[ADDR_W-2:0], io[0]};
		endcase
	endfunction : shift_in

	// Next byte address, kept inside the aligned section when wrapping
	function automatic logic [ADDR_W-1:0] next_byte(input logic [ADDR_W-1:0] a, input logic wrap,
	                                               input logic [1:0] len);
		logic [ADDR_W-1:0] mask;
		logic [ADDR_W-1:0] inc;
		// Sections run 8, 16, 32 or 64 bytes, so the mask is the size less one
		mask = ADDR_W'((8'h08 << len) - 8'h01);
		inc  = a + ADDR_W'(1);
		if (wrap) begin
			next_byte = (a & ~mask) | (inc & mask);
		end else begin
			next_byte = inc;
		end
	endfunction : next_byte

	// ----------------------------------------------------------------
	// Register file state
	// ----------------------------------------------------------------
	logic        quad_enable_bit;
	logic        cycle_busy;
	logic        ack;
	logic [31:0] rdata;
	logic        next_quad_enable_bit;
	logic        next_cycle_busy;
	logic        next_ack;
	logic [31:0] next_rdata;

	// ----------------------------------------------------------------
	// Engine state
	// ----------------------------------------------------------------
	sfr_pkg::sfr_state_t state;
	sfr_pkg::sfr_state_t next_state;
	sfr_pkg::sfr_kind_t  kind;
	sfr_pkg::sfr_kind_t  next_kind;
	sfr_pkg::sfr_kind_t  cont_kind;
	sfr_pkg::sfr_kind_t  next_cont_kind;
	logic [4:0]          cnt;
	logic [4:0]          next_cnt;
	logic [ADDR_W-1:0]   addr;
	logic [ADDR_W-1:0]   next_addr;
	logic [7:0]          mode_byte;
	logic [7:0]          next_mode_byte;
	logic                continuous_mode_bits;
	logic                next_continuous_mode_bits;
	logic                wrap_disable_bit;
	logic                next_wrap_disable_bit;
	logic [1:0]          wrap_length_field;
	logic [1:0]          next_wrap_length_field;
	logic [7:0]          out_sh;
	logic [7:0]          next_out_sh;
	logic [3:0]          out_left;
	logic [3:0]          next_out_left;
	logic [3:0]          io_q;
	logic [3:0]          next_io_q;
	logic [3:0]          oe_q;
	logic [3:0]          next_oe_q;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Ack one clock after the strobe; the write lands on the edge that ends the ack
	always_comb begin
		next_quad_enable_bit = quad_enable_bit;
		next_cycle_busy      = cycle_busy;
		next_ack             = wb_cyc_i & wb_stb_i & ~ack;
		next_rdata           = rdata;
		if (wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0] && (wb_adr_i == sfr_pkg::OFS_CTRL)) begin
			next_quad_enable_bit = wb_dat_i[sfr_pkg::CTRL_QE_POS];
			next_cycle_busy      = wb_dat_i[sfr_pkg::CTRL_BUSY_POS];
		end
		if (wb_cyc_i && wb_stb_i && !ack) begin
			unique case (wb_adr_i)
				sfr_pkg::OFS_CTRL:   next_rdata = {30'h0, cycle_busy, quad_enable_bit};
				sfr_pkg::OFS_STATUS: next_rdata = {24'h0, ~cs_n, state, wrap_length_field,
				                                   wrap_disable_bit, continuous_mode_bits};
				sfr_pkg::OFS_ADDR:   next_rdata = 32'(addr);
				default:             next_rdata = 32'h0;   // Unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{cycle_busy, quad_enable_bit} <= sfr_pkg::CTRL_RESET;
			ack                           <= 1'b0;
			rdata                         <= 32'h0;
		end else begin
			quad_enable_bit <= next_quad_enable_bit;
			cycle_busy      <= next_cycle_busy;
			ack             <= next_ack;
			rdata           <= next_rdata;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	// Inputs act on rising serial edges, outputs on falling ones
	always_comb begin
		next_state                = state;
		next_kind                 = kind;
		next_cont_kind            = cont_kind;
		next_cnt                  = cnt;
		next_addr                 = addr;
		next_mode_byte            = mode_byte;
		next_continuous_mode_bits = continuous_mode_bits;
		next_wrap_disable_bit     = wrap_disable_bit;
		next_wrap_length_field    = wrap_length_field;
		next_out_sh               = out_sh;
		next_out_left             = out_left;
		next_io_q                 = io_q;
		next_oe_q                 = oe_q;
		if (cs_n) begin
			next_state = sfr_pkg::ST_IDLE;                           // [R23]
			next_oe_q  = 4'h0;                                       // [R23]
			next_cnt   = 5'h00;
		end else begin
			unique case (state)
				sfr_pkg::ST_IDLE: begin
					next_cnt = 5'h00;
					if (continuous_mode_bits) begin
						next_kind  = cont_kind;                      // [R9] [R12] [R15]
						next_state = cycle_busy ? sfr_pkg::ST_IGNORE : sfr_pkg::ST_ADDR;  // [R4]
					end else begin
						next_state = sfr_pkg::ST_CMD;
					end
				end
				sfr_pkg::ST_CMD: begin
					if (sclk_rise) begin
						next_mode_byte = {mode_byte[6:0], io_in[0]};  // [R1]
						next_cnt       = cnt + 5'h01;
						if (next_cnt == sfr_pkg::CMD_CLOCKS) begin
							next_cnt   = 5'h00;
							next_state = sfr_pkg::ST_ADDR;
							unique case (next_mode_byte)
								sfr_pkg::CMD_READ:      next_kind = sfr_pkg::K_READ;   // [R1]
								sfr_pkg::CMD_FAST:      next_kind = sfr_pkg::K_FAST;   // [R5]
								sfr_pkg::CMD_DUAL_OUT:  next_kind = sfr_pkg::K_DOUT;   // [R6]
								sfr_pkg::CMD_QUAD_OUT:  next_kind = sfr_pkg::K_QOUT;   // [R7]
								sfr_pkg::CMD_DUAL_IO:   next_kind = sfr_pkg::K_DIO;    // [R8]
								sfr_pkg::CMD_QUAD_IO:   next_kind = sfr_pkg::K_QIO;    // [R10]
								sfr_pkg::CMD_QUAD_WORD: next_kind = sfr_pkg::K_QWORD;  // [R13]
								sfr_pkg::CMD_SET_WRAP: begin
									next_kind  = sfr_pkg::K_WRAP;
									next_state = sfr_pkg::ST_WRAP;    // [R19]
								end
								default:                next_state = sfr_pkg::ST_IGNORE;
							endcase
							// Quad I/O forms need quad enable; reads during a busy cycle are ignored
							if ((next_kind == sfr_pkg::K_QIO || next_kind == sfr_pkg::K_QWORD)
							    && !quad_enable_bit) begin
								next_state = sfr_pkg::ST_IGNORE;      // [R11] [R14]
							end
							if (cycle_busy && next_state == sfr_pkg::ST_ADDR) begin
								next_state = sfr_pkg::ST_IGNORE;      // [R4]
							end
						end
					end
				end
				sfr_pkg::ST_ADDR: begin
					if (sclk_rise) begin
						next_addr = shift_in(addr, addr_lanes(kind), io_in);  // [R21]
						next_cnt  = cnt + 5'h01;
						if (next_cnt == addr_clocks(kind)) begin
							next_cnt = 5'h00;
							if (has_mode(kind)) begin
								next_state = sfr_pkg::ST_MODE;
							end else if (dummy_clocks(kind) != 5'h00) begin
								next_state = sfr_pkg::ST_DUMMY;      // [R5] [R6] [R7]
							end else begin
								next_state    = sfr_pkg::ST_DATA;    // [R2]
								next_out_left = 4'h0;
							end
						end
					end
				end
				sfr_pkg::ST_MODE: begin
					if (sclk_rise) begin
						next_mode_byte = 8'(shift_in(ADDR_W'(mode_byte), addr_lanes(kind), io_in));
						next_cnt       = cnt + 5'h01;
						if (next_cnt == ((kind == sfr_pkg::K_DIO) ? sfr_pkg::MODE_CLOCKS_X2
						                                          : sfr_pkg::MODE_CLOCKS_X4)) begin
							next_cnt = 5'h00;
							// Mode bits 10 arm the next transaction without a command code
							next_continuous_mode_bits = (next_mode_byte[5:4] == sfr_pkg::CONT_MODE_MATCH);  // [R9] [R12] [R15] [R16]
							next_cont_kind            = kind;
							if (dummy_clocks(kind) != 5'h00) begin
								next_state = sfr_pkg::ST_DUMMY;      // [R10] [R13]
							end else begin
								next_state    = sfr_pkg::ST_DATA;    // [R8]
								next_out_left = 4'h0;
							end
						end
					end
				end
				sfr_pkg::ST_DUMMY: begin
					if (sclk_rise) begin
						next_cnt = cnt + 5'h01;
						if (next_cnt == dummy_clocks(kind)) begin
							next_cnt      = 5'h00;
							next_state    = sfr_pkg::ST_DATA;
							next_out_left = 4'h0;
						end
					end
				end
				sfr_pkg::ST_DATA: begin
					if (sclk_fall) begin
						// Byte boundary: take the fetched byte, move the fetch address on
						if (out_left == 4'h0) begin
							next_out_sh   = mem_data_i << data_lanes(kind);
							next_out_left = 4'h8 - 4'(data_lanes(kind));
							next_io_q     = mem_data_i[7:4];
							next_addr     = next_byte(addr, !wrap_disable_bit &&
							                (kind == sfr_pkg::K_QIO || kind == sfr_pkg::K_QWORD),
							                wrap_length_field);      // [R3] [R17]
						end else begin
							next_out_sh   = out_sh << data_lanes(kind);
							next_out_left = out_left - 4'(data_lanes(kind));
							next_io_q     = out_sh[7:4];
						end
						unique case (data_lanes(kind))
							3'h2: begin
								next_io_q = {2'h0, next_io_q[3:2]};  // [R6] [R22]
								next_oe_q = 4'h3;
							end
							3'h4: begin
								next_oe_q = 4'hF;                    // [R7] [R10]
							end
							default: begin
								next_io_q = {2'h0, next_io_q[3], 1'b0};  // [R2] [R5]
								next_oe_q = 4'h2;
							end
						endcase
					end
				end
				sfr_pkg::ST_WRAP: begin
					if (sclk_rise) begin
						next_cnt = cnt + 5'h01;
						if (cnt == sfr_pkg::WRAP_BITS_CLOCK) begin
							next_mode_byte = {5'h00, io_in[2:0]};   // [R19]
						end
						// The setting changes only once the whole frame is in
						if (next_cnt == sfr_pkg::WRAP_CLOCKS) begin
							next_wrap_disable_bit  = mode_byte[0];     // [R18] [R20]
							next_wrap_length_field = mode_byte[2:1];   // [R18] [R20]
							next_state             = sfr_pkg::ST_IGNORE;
						end
					end
				end
				sfr_pkg::ST_IGNORE: begin
					next_oe_q = 4'h0;                                // [R4]
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state                <= sfr_pkg::ST_IDLE;
			kind                 <= sfr_pkg::K_READ;
			cont_kind            <= sfr_pkg::K_READ;
			cnt                  <= 5'h00;
			addr                 <= '0;
			mode_byte            <= 8'h00;
			continuous_mode_bits <= 1'b0;                            // [R24]
			wrap_disable_bit     <= sfr_pkg::WRAP_DIS_RESET;         // [R24]
			wrap_length_field    <= sfr_pkg::WRAP_LEN_RESET;
			out_sh               <= 8'h00;
			out_left             <= 4'h0;
			io_q                 <= 4'h0;
			oe_q                 <= 4'h0;
		end else begin
			state                <= next_state;
			kind                 <= next_kind;
			cont_kind            <= next_cont_kind;
			cnt                  <= next_cnt;
			addr                 <= next_addr;
			mode_byte            <= next_mode_byte;
			continuous_mode_bits <= next_continuous_mode_bits;
			wrap_disable_bit     <= next_wrap_disable_bit;
			wrap_length_field    <= next_wrap_length_field;
			out_sh               <= next_out_sh;
			out_left             <= next_out_left;
			io_q                 <= next_io_q;
			oe_q                 <= next_oe_q;
		end
	end

	assign io_o       = io_q;
	assign io_oe_o    = oe_q;
	assign mem_addr_o = addr;   // Array sees the byte to send next

endmodule : sfr_engine

// ### tb/sfr_engine_properties.sv
// Concurrent checks on the flash read engine ports
`timescale 1ns/10ps
module sfr_engine_props #(
	parameter int ADDR_W = 24
) (
	input logic              clk_i,
	input logic              rst_i,
	input logic [7:0]        wb_adr_i,
	input logic [31:0]       wb_dat_i,
	input logic [3:0]        wb_sel_i,
	input logic              wb_we_i,
	input logic              wb_cyc_i,
	input logic              wb_stb_i,
	input logic [31:0]       wb_dat_o,
	input logic              wb_ack_o,
	input logic              sclk_i,
	input logic              cs_n_i,
	input logic [3:0]        io_i,
	input logic [3:0]        io_o,
	input logic [3:0]        io_oe_o,
	input logic [ADDR_W-1:0] mem_addr_o,
	input logic [7:0]        mem_data_i
);
	// Clocks since the raw serial clock fell; saturates so long idles stay legal
	logic       sclk_d;
	logic [3:0] fall_cnt;
	logic [3:0] next_fall_cnt;
	always_comb begin
		next_fall_cnt = (rst_i || fall_cnt == 4'hF) ? 4'hF : fall_cnt + 4'h1;
		if (sclk_d && !sclk_i) next_fall_cnt = 4'h0;
	end
	always_ff @(posedge clk_i) begin
		sclk_d   <= sclk_i;
		fall_cnt <= next_fall_cnt;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	a_ack_follows: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && !($past(wb_adr_i) inside {8'h00, 8'h04, 8'h08})
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_lane_set: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal lane enable set");
	a_select_release: assert property ($rose(cs_n_i) |-> ##[1:6] io_oe_o == 4'h0)
		else $error("lanes still driven after select high");
	a_out_on_fall: assert property ($changed(io_o) && io_oe_o != 4'h0 && $past(io_oe_o) != 4'h0
		|-> fall_cnt inside {[4'h1:4'h5]}) else $error("data changed away from falling edge");
	a_addr_step: assert property (io_oe_o != 4'h0 && $changed(mem_addr_o)
		|-> mem_addr_o == $past(mem_addr_o) + 1'b1 || (mem_addr_o ^ $past(mem_addr_o)) < ADDR_W'(64))
		else $error("address step wrong");
endmodule : sfr_engine_props

bind sfr_engine sfr_engine_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ### tb/sfr_host_model.sv
// Host controller model driving the serial flash pins
`timescale 1ns/10ps
module sfr_host_model (
	output logic       sclk_o,
	output logic       cs_n_o,
	output logic [3:0] drv_o,
	output logic [3:0] en_o,
	input  logic [3:0] line_i
);
	// Serial clock idles low between frames; half period of the 125 ns link clock
	localparam real HALF = 62.5;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		drv_o  = 4'h0;
		en_o   = 4'h0;
	end
	// Select edges with a settling gap on each side
	task automatic sel(input logic v);
		#(HALF) cs_n_o = v;
		en_o = 4'h0;
		#(HALF);
	endtask : sel
	// Header bits MSB first, w lanes per clock, set up while the clock is low
	task automatic send(input logic [31:0] v, input int n, input int w);
		for (int i = n - w; i >= 0; i -= w) begin
			en_o  = 4'hF >> (4 - w);
			drv_o = 4'(v >> i) & en_o;
			#(HALF) sclk_o = 1'b1;
			#(HALF) sclk_o = 1'b0;
		end
		en_o = 4'h0;
	endtask : send
	// Data changes after a fall, so it is taken just before the next rise
	task automatic recv(input int w, output logic [7:0] b);
		for (int i = 0; i < 8; i += w) begin
			#(HALF) b = (b << w) | 8'(w == 1 ? {3'h0, line_i[1]} : line_i & (4'hF >> (4 - w)));
			sclk_o = 1'b1;
			#(HALF) sclk_o = 1'b0;
		end
	endtask : recv
endmodule : sfr_host_model

// ### tb/tb.sv
// Self-checking bench for the serial flash read engine
`timescale 1ns/10ps
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, tog = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00, b, mem_data_i;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0]  wb_sel_i = 4'hF, io_i, io_o, io_oe_o, h_drv, h_en;
	logic        wb_ack_o, sclk_i, cs_n_i;
	logic [23:0] mem_addr_o, a;
	int          n_fail = 0, compares = 0, seed = 5635;
	initial forever #2 clk_i = ~clk_i;
	// Released lanes toggle every cycle so a stale value can never pass
	always @(posedge clk_i) tog <= ~tog;
	assign io_i = (io_oe_o & io_o) | (~io_oe_o & h_en & h_drv) | (~io_oe_o & ~h_en & {4{tog}});
	function automatic logic [7:0] exp_byte(input logic [23:0] ad);
		return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ 8'h5A;
	endfunction : exp_byte
	assign mem_data_i = exp_byte(mem_addr_o);
	sfr_engine DUT (.*);
	sfr_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .drv_o(h_drv), .en_o(h_en), .line_i(io_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
		int t = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
		wb_adr_i <= ad;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
		if (t >= 50) chk(32'h0, 32'h1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	// One frame; cmd 0 skips the code, ign expects the lanes to stay released
	task automatic frame(input logic [7:0] cmd, input logic [31:0] hdr, input int hb, hw, dmy, dw, n,
		input logic [7:0] wm, input logic ign);
		logic [23:0] e;
		host.sel(1'b0);
		if (cmd != 8'h00) host.send({24'h0, cmd}, 8, 1);
		host.send(hdr, hb, hw);
		if (dmy > 0) host.send(32'h0, dmy * hw, hw);
		for (int i = 0; i < n; i++) begin
			host.recv(dw, b);
			e = (hb == 32 ? hdr[31:8] : hdr[23:0]) + 24'(i);
			if (wm != 8'hFF) e = {hdr[31:16], hdr[15:8] & ~wm | e[7:0] & wm};
			if (ign) chk(io_oe_o, 4'h0);
			else chk(b, exp_byte(e));
		end
		host.sel(1'b1);
	endtask : frame
	task automatic final_report;
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		static logic [7:0] cmds [4] = '{sfr_pkg::CMD_READ, sfr_pkg::CMD_FAST,
			sfr_pkg::CMD_DUAL_OUT, sfr_pkg::CMD_QUAD_OUT};
		static int dmys [4] = '{0, 8, 8, 8};
		static int wids [4] = '{1, 1, 2, 4};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h2);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		foreach (cmds[k]) begin
			a = 24'($random(seed));
			frame(cmds[k], {8'h0, a}, 24, 1, dmys[k], wids[k], 3, 8'hFF, 1'b0);
		end
		wb(1'b1, 8'h00, 32'h2);
		frame(sfr_pkg::CMD_READ, {8'h0, a}, 24, 1, 0, 1, 2, 8'hFF, 1'b1);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd[1:0], 2'h2);
		wb(1'b1, 8'h00, 32'h0);
		frame(sfr_pkg::CMD_QUAD_IO, {a, 8'hFF}, 32, 4, 4, 4, 2, 8'hFF, 1'b1);
		frame(sfr_pkg::CMD_QUAD_WORD, {a, 8'hFF}, 32, 4, 2, 4, 2, 8'hFF, 1'b1);
		wb(1'b1, 8'h00, 32'h1);
		for (int k = 0; k < 3; k++) begin
			a = 24'($random(seed)) & 24'hFFFFFE;
			frame(k == 0 ? sfr_pkg::CMD_DUAL_IO : k == 1 ? sfr_pkg::CMD_QUAD_IO : sfr_pkg::CMD_QUAD_WORD,
				{a, 8'h20}, 32, 2 << (k > 0), k == 0 ? 0 : 6 - 2 * k, 2 << (k > 0), 2, 8'hFF, 1'b0);
			wb(1'b0, 8'h04, 32'h0);
			chk(rd[0], 1'b1);
			frame(8'h00, {a, 8'hFF}, 32, 2 << (k > 0), k == 0 ? 0 : 6 - 2 * k, 2 << (k > 0), 2, 8'hFF, 1'b0);
			wb(1'b0, 8'h04, 32'h0);
			chk(rd[0], 1'b0);
		end
		for (int l = 0; l < 5; l++) begin
			host.sel(1'b0);
			host.send({24'h0, sfr_pkg::CMD_SET_WRAP}, 8, 1);
			host.send({24'h0, 1'b0, 2'(l), l == 4, 4'h0}, 32, 4);
			host.sel(1'b1);
			wb(1'b0, 8'h04, 32'h0);
			chk(rd[3:1], {2'(l), l == 4});
			a = 24'($random(seed)) & 24'hFFFFFE;
			if (l < 4) frame(l[0] ? sfr_pkg::CMD_QUAD_WORD : sfr_pkg::CMD_QUAD_IO, {a, 8'hFF}, 32, 4, l[0] ? 2 : 4, 4,
				(8 << l) + 2, 8'((8 << l) - 1), 1'b0);
		end
		final_report();
	end
	initial begin
		#150000;
		n_fail++;
		final_report();
	end
endmodule : tb
